//--- hw/cg_mode_switch.v
/*
  clock generator mode switch: four control registers, one status register, mode decode,
  settled status tracking, lock model and the resulting output and bus clock frequencies.
  assumes software polls status after each mode-select change; reference frequencies are
  parameters, since the oscillators themselves live outside this block.
*/
`timescale 1ns/100ps
`default_nettype none
`include "cg_defs.vh"

module cg_mode_switch #(
    parameter [31:0] INT_REF_HZ = 32'h00007A12,
    parameter [31:0] EXT_REF_HZ = 32'h007A1200,
    parameter SWITCH_CYCLES = `CG_SWITCH_CYC,
    parameter LOCK_CYCLES = `CG_LOCK_CYC,
    parameter OSC_CYCLES = `CG_OSC_CYC
) (
    // clock and reset
    input wire i_clk,
    input wire i_sys_rst,
    // register port
    input wire [2:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    // decoded state
    output reg [7:0] o_mode,
    output reg [10:0] o_fll_factor,
    output reg o_fll_enable,
    output reg o_pll_enable,
    output reg o_lock,
    // oscillator controls
    output reg o_osc_enable,
    output reg o_high_gain,
    output reg o_freq_range,
    output reg o_ext_ref_clock_enable,
    // resulting frequencies in Hz
    output reg [31:0] o_clock_output_hz,
    output reg [31:0] o_bus_clock_hz
);

    localparam [7:0] MODE_FLL_INT = 8'h01;
    localparam [7:0] MODE_FLL_EXT = 8'h02;
    localparam [7:0] MODE_BYP_INT = 8'h04;
    localparam [7:0] MODE_BYP_EXT = 8'h08;
    localparam [7:0] MODE_PLL_EXT = 8'h10;
    localparam [7:0] MODE_PBY_EXT = 8'h20;
    localparam [7:0] MODE_LOW_INT = 8'h40;
    localparam [7:0] MODE_LOW_EXT = 8'h80;

    reg [7:0] ctrl_one_q;
    reg [7:0] ctrl_two_q;
    reg [7:0] ctrl_three_q;
    reg [7:0] ctrl_four_q;

    wire [1:0] clock_source_select = ctrl_one_q[`CG_C1_SRC_HI:`CG_C1_SRC_LO];
    wire [2:0] ref_divider = ctrl_one_q[`CG_C1_REFDIV_HI:`CG_C1_REFDIV_LO];
    wire internal_ref_select = ctrl_one_q[`CG_C1_INTREF];
    wire [1:0] output_divider = ctrl_two_q[`CG_C2_OUTDIV_HI:`CG_C2_OUTDIV_LO];
    wire low_power_bypass = ctrl_two_q[`CG_C2_LOWPWR];
    wire oscillator_request = ctrl_two_q[`CG_C2_OSCREQ];
    wire loop_select = ctrl_three_q[`CG_C3_LOOP];
    wire extra_ref_divide = ctrl_three_q[`CG_C3_XDIV];
    wire [3:0] pll_multiplier = ctrl_three_q[`CG_C3_MULT_HI:`CG_C3_MULT_LO];
    wire [1:0] dco_range_select = ctrl_four_q[`CG_C4_DCO_HI:`CG_C4_DCO_LO];
    wire low_ref_max_multiplier = ctrl_four_q[`CG_C4_DMX];

    wire loop_select_status;
    wire internal_ref_status;
    wire [1:0] clock_source_settled;
    wire oscillator_ready;

    wire [7:0] reset_one = `CG_RST_CTRL_ONE;
    wire [7:0] reset_three = `CG_RST_CTRL_THREE;

    // register writes
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            ctrl_one_q <= `CG_RST_CTRL_ONE;
            ctrl_two_q <= `CG_RST_CTRL_TWO;
            ctrl_three_q <= `CG_RST_CTRL_THREE;
            ctrl_four_q <= `CG_RST_CTRL_FOUR;
        end
        else if (i_wr)
        begin
            case (i_addr)
                `CG_ADDR_CTRL_ONE: ctrl_one_q <= i_wdata;
                `CG_ADDR_CTRL_TWO: ctrl_two_q <= {i_wdata[7:1], 1'b0};
                // loop and multiplier stay writable in low power; they only stage the next mode
                `CG_ADDR_CTRL_THREE: ctrl_three_q <= {1'b0, i_wdata[6], 1'b0, i_wdata[4:0]};
                `CG_ADDR_CTRL_FOUR:
                begin
                    ctrl_four_q[`CG_C4_DMX] <= i_wdata[`CG_C4_DMX];
                    if (!low_power_bypass && !loop_select)
                    begin
                        ctrl_four_q[`CG_C4_DCO_HI:`CG_C4_DCO_LO] <= i_wdata[`CG_C4_DCO_HI:`CG_C4_DCO_LO];
                    end
                end
                default: ctrl_one_q <= ctrl_one_q;
            endcase
        end
    end

    // each select is mirrored only after the switch has had time to complete
    cg_settle #(.W(1), .DELAY(SWITCH_CYCLES)) u_loop_settle (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_req(loop_select),
        .i_init(reset_three[`CG_C3_LOOP]),
        .o_status(loop_select_status)
    );

    cg_settle #(.W(1), .DELAY(SWITCH_CYCLES)) u_ref_settle (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_req(internal_ref_select),
        .i_init(reset_one[`CG_C1_INTREF]),
        .o_status(internal_ref_status)
    );

    cg_settle #(.W(2), .DELAY(SWITCH_CYCLES)) u_source_settle (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_req(clock_source_select),
        .i_init(reset_one[`CG_C1_SRC_HI:`CG_C1_SRC_LO]),
        .o_status(clock_source_settled)
    );

    cg_settle #(.W(1), .DELAY(OSC_CYCLES)) u_osc_settle (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_req(oscillator_request),
        .i_init(1'b0),
        .o_status(oscillator_ready)
    );

    // low power only takes hold in the two bypass sources
    reg low_power_active;
    reg [1:0] clock_source_status;
    reg [7:0] mode;

    always @*
    begin
        low_power_active = low_power_bypass &&
            (clock_source_settled == 2'b01 || clock_source_settled == 2'b10);
        clock_source_status = (clock_source_settled == 2'b01 || clock_source_settled == 2'b10) ?
            clock_source_settled : (loop_select_status ? 2'b11 : 2'b00);
        case (clock_source_settled)
            2'b01: mode = low_power_active ? MODE_LOW_INT : MODE_BYP_INT;
            2'b10:
            begin
                if (low_power_active)
                begin
                    mode = MODE_LOW_EXT;
                end
                else
                begin
                    mode = loop_select_status ? MODE_PBY_EXT : MODE_BYP_EXT;
                end
            end
            default:
            begin
                // reserved source code 11 is treated as the loop output
                if (internal_ref_status)
                begin
                    mode = MODE_FLL_INT;
                end
                else
                begin
                    mode = loop_select_status ? MODE_PLL_EXT : MODE_FLL_EXT;
                end
            end
        endcase
    end

    // loop factors and dividers
    reg [10:0] fll_factor;
    reg [3:0] fll_ref_shift;
    reg fll_on;
    reg pll_on;
    wire [5:0] pll_mult = {pll_multiplier, 2'b00};

    always @*
    begin
        case ({low_ref_max_multiplier, dco_range_select})
            3'b000: fll_factor = `CG_FLL_F512;
            3'b001: fll_factor = `CG_FLL_F1024;
            3'b010: fll_factor = `CG_FLL_F1536;
            3'b100: fll_factor = `CG_FLL_F608;
            3'b101: fll_factor = `CG_FLL_F1216;
            3'b110: fll_factor = `CG_FLL_F1824;
            default: fll_factor = `CG_FLL_F512;
        endcase
        // extra divide only reaches the FLL path; the PLL path never sees it
        if (extra_ref_divide)
        begin
            fll_ref_shift = {1'b0, ref_divider} + `CG_FLL_EXTRA_SHIFT;
        end
        else
        begin
            fll_ref_shift = {1'b0, ref_divider};
        end
        fll_on = !loop_select_status && !low_power_active;
        pll_on = loop_select_status && !low_power_active;
    end

    // output frequency per mode
    reg [42:0] product;
    reg [31:0] clock_output;

    always @*
    begin
        case (mode)
            MODE_FLL_INT: product = INT_REF_HZ * fll_factor;
            MODE_FLL_EXT: product = (EXT_REF_HZ >> fll_ref_shift) * fll_factor;
            MODE_PLL_EXT: product = (EXT_REF_HZ >> ref_divider) * pll_mult;
            MODE_BYP_INT: product = {11'h000, INT_REF_HZ};
            MODE_LOW_INT: product = {11'h000, INT_REF_HZ};
            MODE_BYP_EXT: product = {11'h000, EXT_REF_HZ};
            MODE_PBY_EXT: product = {11'h000, EXT_REF_HZ};
            MODE_LOW_EXT: product = {11'h000, EXT_REF_HZ};
            default: product = 43'h000_0000_0000;
        endcase
        clock_output = product[31:0] >> output_divider;
    end

    // lock model: lock restarts whenever anything the running loop depends on moves
    reg [23:0] loop_cfg_q;
    reg [15:0] lock_cnt_q;
    wire [23:0] loop_cfg = {loop_select_status, internal_ref_status, low_ref_max_multiplier,
        dco_range_select, ref_divider, extra_ref_divide && !loop_select_status,
        pll_multiplier & {4{loop_select_status}}, 11'h000};
    wire loop_running = fll_on || pll_on;

    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            loop_cfg_q <= 24'h000000;
            lock_cnt_q <= 16'h0000;
            o_lock <= 1'b0;
        end
        else
        begin
            loop_cfg_q <= loop_cfg;
            if (!loop_running || loop_cfg != loop_cfg_q)
            begin
                lock_cnt_q <= 16'h0000;
                o_lock <= 1'b0;
            end
            else if (lock_cnt_q == LOCK_CYCLES[15:0] - 16'h0001)
            begin
                o_lock <= 1'b1;
            end
            else
            begin
                lock_cnt_q <= lock_cnt_q + 16'h0001;
            end
        end
    end

    // registered outputs
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_mode <= MODE_FLL_INT;
            o_fll_factor <= `CG_FLL_F512;
            o_fll_enable <= 1'b1;
            o_pll_enable <= 1'b0;
            o_osc_enable <= 1'b0;
            o_high_gain <= 1'b0;
            o_freq_range <= 1'b0;
            o_ext_ref_clock_enable <= 1'b0;
            o_clock_output_hz <= 32'h0000_0000;
            o_bus_clock_hz <= 32'h0000_0000;
        end
        else
        begin
            o_mode <= mode;
            o_fll_factor <= fll_factor;
            o_fll_enable <= fll_on;
            o_pll_enable <= pll_on;
            o_osc_enable <= oscillator_request;
            o_high_gain <= ctrl_two_q[`CG_C2_GAIN];
            o_freq_range <= ctrl_two_q[`CG_C2_RANGE];
            o_ext_ref_clock_enable <= ctrl_two_q[`CG_C2_EXTEN];
            o_clock_output_hz <= clock_output;
            o_bus_clock_hz <= clock_output >> 1;
        end
    end

    // read port: data stand in the cycle after the strobe only
    reg [7:0] status_word;

    always @*
    begin
        status_word = 8'h00;
        status_word[`CG_SC_LOCK] = o_lock;
        status_word[`CG_SC_LOOPST] = loop_select_status;
        status_word[`CG_SC_REFST] = internal_ref_status;
        status_word[`CG_SC_SRCST_HI:`CG_SC_SRCST_LO] = clock_source_status;
        status_word[`CG_SC_OSCRDY] = oscillator_ready;
    end

    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_rdata <= 8'h00;
        end
        else if (i_rd)
        begin
            case (i_addr)
                `CG_ADDR_CTRL_ONE: o_rdata <= ctrl_one_q;
                `CG_ADDR_CTRL_TWO: o_rdata <= ctrl_two_q;
                `CG_ADDR_CTRL_THREE: o_rdata <= ctrl_three_q;
                `CG_ADDR_CTRL_FOUR: o_rdata <= ctrl_four_q;
                `CG_ADDR_STATUS: o_rdata <= status_word;
                default: o_rdata <= 8'h00;
            endcase
        end
        else
        begin
            o_rdata <= 8'h00;
        end
    end

endmodule

`default_nettype wire

//--- inc/cg_defs.vh
/*
  register map, field positions, reset values and settle times of the clock generator mode switch.
  assumes a 50 MHz system clock and an 8-bit register port with a 3-bit address.
*/
`ifndef CG_DEFS_VH
`define CG_DEFS_VH

`define CG_ADDR_CTRL_ONE   3'h0
`define CG_ADDR_CTRL_TWO   3'h1
`define CG_ADDR_CTRL_THREE 3'h2
`define CG_ADDR_CTRL_FOUR  3'h3
`define CG_ADDR_STATUS     3'h4

`define CG_C1_SRC_HI 7
`define CG_C1_SRC_LO 6
`define CG_C1_REFDIV_HI 5
`define CG_C1_REFDIV_LO 3
`define CG_C1_INTREF 2
`define CG_C2_OUTDIV_HI 7
`define CG_C2_OUTDIV_LO 6
`define CG_C2_RANGE 5
`define CG_C2_GAIN 4
`define CG_C2_LOWPWR 3
`define CG_C2_OSCREQ 2
`define CG_C2_EXTEN 1
`define CG_C3_LOOP 6
`define CG_C3_XDIV 4
`define CG_C3_MULT_HI 3
`define CG_C3_MULT_LO 0
`define CG_C4_DCO_HI 7
`define CG_C4_DCO_LO 6
`define CG_C4_DMX 5
`define CG_SC_LOCK 6
`define CG_SC_LOOPST 5
`define CG_SC_REFST 4
`define CG_SC_SRCST_HI 3
`define CG_SC_SRCST_LO 2
`define CG_SC_OSCRDY 1

`define CG_RST_CTRL_ONE   8'h04
`define CG_RST_CTRL_TWO   8'h40
`define CG_RST_CTRL_THREE 8'h01
`define CG_RST_CTRL_FOUR  8'h00

`define CG_FLL_F512  11'h200
`define CG_FLL_F1024 11'h400
`define CG_FLL_F1536 11'h600
`define CG_FLL_F608  11'h260
`define CG_FLL_F1216 11'h4C0
`define CG_FLL_F1824 11'h720
`define CG_FLL_EXTRA_SHIFT 4'h5

`define CG_CLK_NS      20
`define CG_SWITCH_NS   100
`define CG_LOCK_NS     1000
`define CG_OSC_NS      2000
`define CG_SWITCH_CYC  ((`CG_SWITCH_NS + `CG_CLK_NS - 1) / `CG_CLK_NS)
`define CG_LOCK_CYC    ((`CG_LOCK_NS + `CG_CLK_NS - 1) / `CG_CLK_NS)
`define CG_OSC_CYC     ((`CG_OSC_NS + `CG_CLK_NS - 1) / `CG_CLK_NS)

`endif

//--- hw/cg_settle.v
/*
  settle tracker: a status copy that follows its request only after the request
  has differed from it for a fixed number of cycles.
  assumes request and status live on i_clk.
*/
`timescale 1ns/100ps
`default_nettype none

module cg_settle #(
    parameter W = 1,
    parameter DELAY = 5
) (
    // clock and reset
    input wire i_clk,
    input wire i_sys_rst,
    // request and reset value
    input wire [W-1:0] i_req,
    input wire [W-1:0] i_init,
    // settled status
    output reg [W-1:0] o_status
);

    reg [15:0] cnt_q;

    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            cnt_q <= 16'h0000;
        end
        else if (i_req == o_status)
        begin
            cnt_q <= 16'h0000;
        end
        else if (cnt_q == DELAY[15:0] - 16'h0001)
        begin
            cnt_q <= 16'h0000;
        end
        else
        begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // the reset value is a strap from the register reset constants, caught on the clock
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_status <= i_init;
        end
        else if (i_req != o_status && cnt_q == DELAY[15:0] - 16'h0001)
        begin
            o_status <= i_req;
        end
    end

endmodule

`default_nettype wire

//--- bench/cg_mode_switch_props.sv
/*
  concurrent checks on the top ports of the clock generator mode switch.
  assumes one clock, synchronous active-high reset, and is bound to every cg_mode_switch instance.
*/
`timescale 1ns/100ps
`default_nettype none
module cg_mode_switch_props #(
    parameter [31:0] INT_REF_HZ = 32'h00007A12,
    parameter [31:0] EXT_REF_HZ = 32'h007A1200,
    parameter SWITCH_CYCLES = 5,
    parameter LOCK_CYCLES = 50,
    parameter OSC_CYCLES = 100
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // register port
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // decoded state, controls and frequencies
    input wire logic [7:0] o_mode,
    input wire logic [10:0] o_fll_factor,
    input wire logic o_fll_enable,
    input wire logic o_pll_enable,
    input wire logic o_lock,
    input wire logic o_osc_enable,
    input wire logic o_high_gain,
    input wire logic o_freq_range,
    input wire logic o_ext_ref_clock_enable,
    input wire logic [31:0] o_clock_output_hz,
    input wire logic [31:0] o_bus_clock_hz
);
    logic [7:0] sh1_q, sh2_q, sh3_q, sh4_q, since_q, rd_msk, exp_rd;
    logic [1:0] quiet_q;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    function automatic logic [10:0] fll_fac(input logic [2:0] sel);
        case (sel)
            3'h1: fll_fac = 11'h400;
            3'h2: fll_fac = 11'h600;
            3'h4: fll_fac = 11'h260;
            3'h5: fll_fac = 11'h4C0;
            3'h6: fll_fac = 11'h720;
            default: fll_fac = 11'h200;
        endcase
    endfunction
    // shadow copy of the control registers, so outputs can be tied to what software wrote
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            sh1_q <= 8'h04;
            sh2_q <= 8'h40;
            sh3_q <= 8'h01;
            sh4_q <= 8'h00;
            quiet_q <= 2'h0;
            since_q <= 8'h00;
        end
        else
        begin
            if (i_wr && i_addr == 3'h0) sh1_q <= i_wdata;
            if (i_wr && i_addr == 3'h1) sh2_q <= i_wdata & 8'hFE;
            if (i_wr && i_addr == 3'h2) sh3_q <= i_wdata & 8'h5F;
            if (i_wr && i_addr == 3'h3) sh4_q <= (sh2_q[3] || sh3_q[6]) ? {sh4_q[7:6], i_wdata[5], 5'h00} :
                {i_wdata[7:5], 5'h00};
            quiet_q <= i_wr ? 2'h0 : ((quiet_q == 2'h3) ? 2'h3 : quiet_q + 2'h1);
            since_q <= (since_q == 8'hFF) ? since_q : since_q + 8'h01;
        end
    end
    assign rd_msk = (i_addr == 3'h4) ? 8'h00 : ((i_addr == 3'h3) ? 8'hE0 : 8'hFF);
    assign exp_rd = (i_addr == 3'h0) ? sh1_q : (i_addr == 3'h1) ? sh2_q : (i_addr == 3'h2) ? sh3_q :
        (i_addr == 3'h3) ? sh4_q : 8'h00;

    bus_half_a: assert property (o_bus_clock_hz == (o_clock_output_hz >> 1))
        else $error("bus clock is not half the output clock");
    reset_mode_a: assert property (disable iff (1'b0) i_sys_rst |=> o_mode == 8'h01 && !o_lock)
        else $error("mode after reset is not fll internal");
    mode_onehot_a: assert property ($onehot(o_mode))
        else $error("mode is not one-hot");
    reg_readback_a: assert property ($past(i_rd) |-> (o_rdata & $past(rd_msk)) == $past(exp_rd))
        else $error("read data differs from written register");
    osc_mirror_a: assert property (quiet_q == 2'h3 |-> {o_freq_range, o_high_gain, o_osc_enable,
        o_ext_ref_clock_enable} == {sh2_q[5], sh2_q[4], sh2_q[2], sh2_q[1]})
        else $error("oscillator controls do not follow second register");
    fll_factor_a: assert property (quiet_q == 2'h3 |-> o_fll_factor == fll_fac({sh4_q[5], sh4_q[7:6]}))
        else $error("fll factor wrong for range and multiplier bits");
    pll_settle_a: assert property ($rose(o_pll_enable) |-> $past(sh3_q[6], SWITCH_CYCLES - 1))
        else $error("pll enabled before loop select settled");
    lock_idle_a: assert property (!(o_fll_enable || o_pll_enable) [*2] |-> !o_lock)
        else $error("lock set with no loop running");
    lock_wait_a: assert property (o_lock |-> since_q >= LOCK_CYCLES)
        else $error("lock set too soon after reset");
    int_freq_a: assert property (o_mode == 8'h01 && $past(o_mode) == 8'h01 && quiet_q == 2'h3 |->
        o_clock_output_hz == ((INT_REF_HZ * {21'h0, o_fll_factor}) >> sh2_q[7:6]))
        else $error("internal fll output frequency wrong");
    pll_ext_c: cover property (o_mode == 8'h10);
    low_ext_c: cover property (o_mode == 8'h80);
    lock_c: cover property ($rose(o_lock));
endmodule
bind cg_mode_switch cg_mode_switch_props #(.INT_REF_HZ(INT_REF_HZ), .EXT_REF_HZ(EXT_REF_HZ),
    .SWITCH_CYCLES(SWITCH_CYCLES), .LOCK_CYCLES(LOCK_CYCLES), .OSC_CYCLES(OSC_CYCLES)) u_props (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_mode(o_mode), .o_fll_factor(o_fll_factor), .o_fll_enable(o_fll_enable),
    .o_pll_enable(o_pll_enable), .o_lock(o_lock), .o_osc_enable(o_osc_enable), .o_high_gain(o_high_gain),
    .o_freq_range(o_freq_range), .o_ext_ref_clock_enable(o_ext_ref_clock_enable),
    .o_clock_output_hz(o_clock_output_hz), .o_bus_clock_hz(o_bus_clock_hz));
`default_nettype wire

//--- bench/cg_mode_switch_tb_top.sv
/*
  self-checking bench for the clock generator mode switch: register model, mode walk, frequencies.
  assumes the design settle counts set small below and a 50 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module cg_mode_switch_tb_top;
    localparam [31:0] INT_HZ = 32'h00007A12;
    localparam [31:0] EXT_HZ = 32'h007A1200;
    logic i_clk = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
    logic [2:0] i_addr = 3'h0;
    logic [7:0] i_wdata = 8'h00, o_rdata, o_mode, d, v;
    logic [10:0] o_fll_factor;
    logic o_fll_enable, o_pll_enable, o_lock, o_osc_enable, o_high_gain, o_freq_range, o_ext_ref_clock_enable;
    logic [31:0] o_clock_output_hz, o_bus_clock_hz;
    logic [7:0] m [0:3];
    integer miscompares = 0, compares = 0, seed = 32'h12bae6bc, i;
    always #10 i_clk = ~i_clk;
    cg_mode_switch #(.INT_REF_HZ(INT_HZ), .EXT_REF_HZ(EXT_HZ), .SWITCH_CYCLES(5), .LOCK_CYCLES(50),
        .OSC_CYCLES(20)) dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_mode(o_mode), .o_fll_factor(o_fll_factor),
        .o_fll_enable(o_fll_enable), .o_pll_enable(o_pll_enable), .o_lock(o_lock), .o_osc_enable(o_osc_enable),
        .o_high_gain(o_high_gain), .o_freq_range(o_freq_range), .o_ext_ref_clock_enable(o_ext_ref_clock_enable),
        .o_clock_output_hz(o_clock_output_hz), .o_bus_clock_hz(o_bus_clock_hz));
    function automatic logic [10:0] fac(input logic [2:0] s);
        case (s)
            3'h1: fac = 11'h400;
            3'h2: fac = 11'h600;
            3'h4: fac = 11'h260;
            3'h5: fac = 11'h4C0;
            3'h6: fac = 11'h720;
            default: fac = 11'h200;
        endcase
    endfunction
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task results;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task wr(input logic [2:0] a, input logic [7:0] x);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= x;
        i_wr <= 1'b1;
        case (a)
            3'h0: m[0] = x;
            3'h1: m[1] = x & 8'hFE;
            3'h2: m[2] = x & 8'h5F;
            3'h3: m[3] = (m[1][3] || m[2][6]) ? {m[3][7:6], x[5], 5'h00} : {x[7:5], 5'h00};
            default: ;
        endcase
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task rd(input logic [2:0] a, output logic [7:0] x);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 x = o_rdata;
    endtask
    task rdchk(input logic [2:0] a);
        rd(a, d);
        chk("readback", d & ((a == 3'h3) ? 8'hE0 : 8'hFF), (a < 3'h4) ? m[a[1:0]] : 8'h00);
    endtask
    // bounded wait for a status field, as software must before its next step
    task poll(input logic [7:0] msk, input logic [7:0] val);
        integer n;
        n = 0;
        d = ~val;
        while (((d & msk) !== val) && n < 200)
        begin
            rd(3'h4, d);
            n++;
        end
        chk("status_poll", d & msk, val);
    endtask
    task settle;
        repeat (4) @(posedge i_clk);
        #1;
    endtask
    initial
    begin
        repeat (30000) @(posedge i_clk);
        miscompares++;
        results;
    end
    initial
    begin
        m[0] = 8'h04;
        m[1] = 8'h40;
        m[2] = 8'h01;
        m[3] = 8'h00;
        repeat (4) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd(3'h4, d);
        chk("status_reset", d, 8'h10);
        wr(3'h6, 8'hFF);
        for (i = 0; i < 8; i++)
            if (i != 4) rdchk(i[2:0]);
        settle;
        chk("mode", o_mode, 8'h01);
        chk("clk_out", o_clock_output_hz, (INT_HZ * 512) >> 1);
        chk("bus_clk", o_bus_clock_hz, (INT_HZ * 512) >> 2);
        for (i = 0; i < 8; i++)
        begin
            wr(3'h3, {i[1:0], i[2], 5'h00});
            settle;
            chk("fll_factor", o_fll_factor, fac({i[2], i[1:0]}));
            chk("clk_out", o_clock_output_hz, (INT_HZ * fac({i[2], i[1:0]})) >> 1);
        end
        poll(8'h40, 8'h40);
        for (i = 0; i < 6; i++)
        begin
            v = 8'($random(seed));
            wr(3'h1, v);
            v = 8'($random(seed));
            wr(3'h3, v);
            settle;
            rdchk(3'h1);
            rdchk(3'h3);
            chk("osc_ctrl", {o_freq_range, o_high_gain, o_osc_enable, o_ext_ref_clock_enable},
                {m[1][5], m[1][4], m[1][2], m[1][1]});
            chk("clk_out", o_clock_output_hz, (INT_HZ * fac({m[3][5], m[3][7:6]})) >> m[1][7:6]);
        end
        wr(3'h1, 8'h36);
        wr(3'h3, 8'h00);
        poll(8'h02, 8'h02);
        wr(3'h2, 8'h11);
        wr(3'h0, 8'h98);
        poll(8'h10, 8'h00);
        poll(8'h0C, 8'h08);
        settle;
        chk("mode", o_mode, 8'h08);
        chk("clk_out", o_clock_output_hz, EXT_HZ);
        wr(3'h1, 8'h3E);
        settle;
        chk("mode", o_mode, 8'h80);
        wr(3'h2, 8'h58);
        repeat (20) @(posedge i_clk);
        #1;
        chk("loops_off", {o_fll_enable, o_pll_enable}, 2'b00);
        wr(3'h3, 8'h40);
        rdchk(3'h3);
        wr(3'h1, 8'h36);
        poll(8'h20, 8'h20);
        poll(8'h40, 8'h40);
        settle;
        chk("mode", o_mode, 8'h20);
        wr(3'h3, 8'h80);
        rdchk(3'h3);
        wr(3'h0, 8'h18);
        poll(8'h0C, 8'h0C);
        settle;
        chk("mode", o_mode, 8'h10);
        chk("clk_out", o_clock_output_hz, (EXT_HZ / 8) * 32);
        chk("bus_clk", o_bus_clock_hz, (EXT_HZ / 8) * 16);
        wr(3'h2, 8'h18);
        poll(8'h20, 8'h00);
        poll(8'h0C, 8'h00);
        settle;
        chk("mode", o_mode, 8'h02);
        chk("clk_out", o_clock_output_hz, (EXT_HZ / 256) * 512);
        wr(3'h3, 8'h40);
        settle;
        chk("clk_out", o_clock_output_hz, (EXT_HZ / 256) * 1024);
        results;
    end
endmodule
`default_nettype wire
